/* verilog/ecu_defs.svh */
// How it works
// - Capture event copies 16-bit timer count
// - Mode picks falling, rising, 4th, 16th, any edge
// - Each capture sets flag; software clears it
// - New capture overwrites unread held value
// - Source select field chooses monitored input
// - Pin level still observed when driven out
// - Mode change may raise spurious flag
// - Prescaler cleared when off, not capture, reset
// - Prescaler change needs control cleared first
// - Only first or third timer; first default
// - Units may share one timer resource
// - Holding register readable as two bytes
// - Sleep stops instruction-clocked timer, external continues
`ifndef ECU_DEFS_SVH
`define ECU_DEFS_SVH
`define ECU_MODE_OFF     4'h0
`define ECU_MODE_ANY     4'h3
`define ECU_MODE_FALL    4'h4
`define ECU_MODE_RISE    4'h5
`define ECU_MODE_RISE4   4'h6
`define ECU_MODE_RISE16  4'h7
`define ECU_PRE_MAX4     4'h3
`define ECU_PRE_MAX16    4'hF
`define ECU_PRE_ONE      4'h1
`define ECU_PRE_ZERO     4'h0
`define ECU_COUNT_ZERO   16'h0000
`define ECU_SRC_PIN      2'h0
`define ECU_SRC_INT0     2'h1
`define ECU_SRC_INT1     2'h2
`define ECU_TMR_FIRST    1'h0
`endif

/* verilog/ecu_pkg.sv */
package ecu_pkg;
  typedef logic [15:0] ecu_count_t;
  typedef logic [3:0]  ecu_mode_t;
  typedef logic [1:0]  ecu_src_t;
endpackage : ecu_pkg

/* verilog/ecu_edge_if.sv */
`timescale 1ns/1ps
interface ecu_edge_if;
  logic levelIn;
  logic rise;
  logic fall;
  modport detector (input levelIn, output rise, output fall);
  modport user     (output levelIn, input rise, input fall);
endinterface : ecu_edge_if

/* verilog/ecu_edge_detect.sv */
`timescale 1ns/1ps
module ecu_edge_detect (
  input  wire logic     ref_clk,
  input  wire logic     reset_n,
  ecu_edge_if.detector  edgeBus
);
  logic [2:0] sync_q;
  logic [2:0] sync_d;

  always_comb begin
    sync_d = {sync_q[1:0], edgeBus.levelIn};
  end

  // Stage 0 feeds only stage 1; edges compare stages 1 and 2
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sync_q <= 3'h0;
    end else begin
      sync_q <= sync_d;
    end
  end

  assign edgeBus.rise = sync_q[1] & ~sync_q[2];
  assign edgeBus.fall = ~sync_q[1] & sync_q[2];
endmodule : ecu_edge_detect

/* verilog/edge_capture_unit.sv */
`timescale 1ns/1ps
`include "ecu_defs.svh"
module edge_capture_unit (
  input  wire logic               ref_clk,
  input  wire logic               reset_n,
  input  wire logic               unitEnable,
  input  wire ecu_pkg::ecu_mode_t captureMode,
  input  wire ecu_pkg::ecu_src_t  captureSourceSel,
  input  wire logic               captureUnitPin,
  input  wire logic [2:0]         internalSources,
  input  wire logic               timerSelect,
  input  wire ecu_pkg::ecu_count_t firstOddTimerCount,
  input  wire ecu_pkg::ecu_count_t secondOddTimerCount,
  input  wire logic               flagClear,
  output logic [7:0]              captureHoldingLow,
  output logic [7:0]              captureHoldingHigh,
  output logic                    captureEventFlag
);
  ecu_edge_if edgeBus ();

  ecu_pkg::ecu_count_t holding_q;
  ecu_pkg::ecu_count_t holding_d;
  logic                flag_q;
  logic                flag_d;
  logic [3:0]          pre_q;
  logic [3:0]          pre_d;
  logic                srcLevel;
  logic                inCapture;
  logic                event_c;
  ecu_pkg::ecu_count_t timerCount;

  // Mode decode shared by the enable logic and the checks
  function automatic logic ecu_is_capture(input ecu_pkg::ecu_mode_t mode);
    logic hit;
    hit = 1'b0;
    case (mode)
      `ECU_MODE_ANY:    hit = 1'b1;
      `ECU_MODE_FALL:   hit = 1'b1;
      `ECU_MODE_RISE:   hit = 1'b1;
      `ECU_MODE_RISE4:  hit = 1'b1;
      `ECU_MODE_RISE16: hit = 1'b1;
      default:          hit = 1'b0;
    endcase
    return hit;
  endfunction : ecu_is_capture

  // Four-bit wrap is intended: the sixteenth rise lands back on zero
  function automatic logic [3:0] ecu_pre_next(input logic [3:0] cur);
    logic [4:0] sum;
    sum = {1'b0, cur} + {1'b0, `ECU_PRE_ONE};
    return sum[3:0];
  endfunction : ecu_pre_next

  // Pin level sampled regardless of pin direction
  always_comb begin
    case (captureSourceSel)
      `ECU_SRC_PIN: srcLevel = captureUnitPin;
      `ECU_SRC_INT0: srcLevel = internalSources[0];
      `ECU_SRC_INT1: srcLevel = internalSources[1];
      default:      srcLevel = internalSources[2];
    endcase
  end

  assign edgeBus.levelIn = srcLevel;

  ecu_edge_detect uEdge (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .edgeBus (edgeBus)
  );

  // Only the two odd timers are selectable; zero picks the first
  // Counts are plain inputs, so any number of units may share one timer
  assign timerCount = (timerSelect == `ECU_TMR_FIRST) ? firstOddTimerCount
                                                      : secondOddTimerCount;

  // No guard on mode changes: a switch may still raise the flag
  assign inCapture = unitEnable && ecu_is_capture(captureMode);

  // Prescaler is not cleared on a direct mode switch
  always_comb begin
    pre_d   = pre_q;
    event_c = 1'b0;
    if (!inCapture) begin
      pre_d = `ECU_PRE_ZERO;
    end else begin
      case (captureMode)
        `ECU_MODE_ANY:  event_c = edgeBus.rise | edgeBus.fall;
        `ECU_MODE_FALL: event_c = edgeBus.fall;
        `ECU_MODE_RISE: event_c = edgeBus.rise;
        `ECU_MODE_RISE4: begin
          if (edgeBus.rise) begin
            event_c = (pre_q >= `ECU_PRE_MAX4);
            pre_d   = event_c ? `ECU_PRE_ZERO : ecu_pre_next(pre_q);
          end
        end
        `ECU_MODE_RISE16: begin
          if (edgeBus.rise) begin
            event_c = (pre_q == `ECU_PRE_MAX16);
            pre_d   = ecu_pre_next(pre_q);
          end
        end
        default: event_c = 1'b0;
      endcase
    end
  end

  always_comb begin
    holding_d = holding_q;
    flag_d    = flag_q;
    if (flagClear) begin
      flag_d = 1'b0;
    end
    // Sleep not modelled: capture runs whenever the clock runs
    if (event_c) begin
      holding_d = timerCount;
      flag_d    = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      holding_q <= `ECU_COUNT_ZERO;
      flag_q    <= 1'b0;
      pre_q     <= `ECU_PRE_ZERO;
    end else begin
      holding_q <= holding_d;
      flag_q    <= flag_d;
      pre_q     <= pre_d;
    end
  end

  // Bytes of one event only while no capture lands between reads
  assign captureHoldingLow  = holding_q[7:0];
  assign captureHoldingHigh = holding_q[15:8];
  assign captureEventFlag   = flag_q;

  a_flag_on_capture: assert property (@(posedge ref_clk) disable iff (!reset_n)
    event_c |=> captureEventFlag) else $error("flag not set");
  a_hold_gets_count: assert property (@(posedge ref_clk) disable iff (!reset_n)
    event_c |=> {captureHoldingHigh, captureHoldingLow} == $past(timerCount))
    else $error("holding wrong");
  a_flag_sticky_hold: assert property (@(posedge ref_clk) disable iff (!reset_n)
    captureEventFlag && !flagClear |=> captureEventFlag) else $error("flag dropped");
  a_pre_clear_off: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !inCapture |=> pre_q == `ECU_PRE_ZERO) else $error("prescaler kept");
  a_hold_only_event: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !event_c |=> $stable(holding_q)) else $error("holding changed");
  a_fall_mode_fall: assert property (@(posedge ref_clk) disable iff (!reset_n)
    inCapture && captureMode == `ECU_MODE_FALL |-> event_c == edgeBus.fall)
    else $error("fall mode");
  a_rise_mode_rise: assert property (@(posedge ref_clk) disable iff (!reset_n)
    inCapture && captureMode == `ECU_MODE_RISE |-> event_c == edgeBus.rise)
    else $error("rise mode");
  a_timer_select: assert property (@(posedge ref_clk) disable iff (!reset_n)
    timerSelect == `ECU_TMR_FIRST |-> timerCount == firstOddTimerCount)
    else $error("timer select");
  a_timer_second: assert property (@(posedge ref_clk) disable iff (!reset_n)
    timerSelect != `ECU_TMR_FIRST |-> timerCount == secondOddTimerCount)
    else $error("second timer");

  // One capture in two steps: event qualified, then both results registered
  sequence s_capture_event;
    inCapture && event_c;
  endsequence

  sequence s_capture_result;
    captureEventFlag && ({captureHoldingHigh, captureHoldingLow} == $past(timerCount));
  endsequence

  property p_capture_steps;
    @(posedge ref_clk) disable iff (!reset_n)
    s_capture_event |=> s_capture_result;
  endproperty

  a_capture_steps: assert property (p_capture_steps) else $error("capture steps");
  a_rise_synced: assert property (@(posedge ref_clk) disable iff (!reset_n)
    edgeBus.rise |-> $past(srcLevel, 2)) else $error("rise unsynced");
  a_fall_synced: assert property (@(posedge ref_clk) disable iff (!reset_n)
    edgeBus.fall |-> !$past(srcLevel, 2)) else $error("fall unsynced");
  a_any_mode_both: assert property (@(posedge ref_clk) disable iff (!reset_n)
    inCapture && captureMode == `ECU_MODE_ANY |-> event_c == (edgeBus.rise | edgeBus.fall))
    else $error("any mode");
  a_idle_no_event: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !inCapture |-> !event_c) else $error("event while off");
  a_flag_clear_drop: assert property (@(posedge ref_clk) disable iff (!reset_n)
    flagClear && !event_c |=> !captureEventFlag) else $error("flag not cleared");
  a_pin_level_seen: assert property (@(posedge ref_clk) disable iff (!reset_n)
    captureSourceSel == `ECU_SRC_PIN |-> srcLevel == captureUnitPin)
    else $error("pin not watched");
  a_byte_pair: assert property (@(posedge ref_clk) disable iff (!reset_n)
    captureHoldingLow == holding_q[7:0] && captureHoldingHigh == holding_q[15:8])
    else $error("byte pair");
  a_rise16_wrap: assert property (@(posedge ref_clk) disable iff (!reset_n)
    inCapture && captureMode == `ECU_MODE_RISE16 && edgeBus.rise && pre_q == `ECU_PRE_MAX16
    |=> pre_q == `ECU_PRE_ZERO) else $error("prescaler wrap");
  a_pre_hold_quiet: assert property (@(posedge ref_clk) disable iff (!reset_n)
    inCapture && captureMode == `ECU_MODE_RISE4 && !edgeBus.rise
    |=> $stable(pre_q)) else $error("prescaler moved");
endmodule : edge_capture_unit

/* sim/ecu_timer_model.sv */
`timescale 1ns/1ps
module ecu_timer_model (
  input  wire logic           ref_clk,
  input  wire logic           reset_n,
  input  wire logic           run,
  output ecu_pkg::ecu_count_t count1,
  output ecu_pkg::ecu_count_t count2
);
  // Stopped timer keeps its count, as an instruction-clocked timer in sleep
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      count1 <= 16'h0000;
      count2 <= 16'hFFF0;
    end else if (run) begin
      count1 <= count1 + 16'h0101;
      count2 <= count2 - 16'h0013;
    end
  end
endmodule : ecu_timer_model

/* sim/edge_capture_unit_tb_top.sv */
`timescale 1ns/1ps
`include "ecu_defs.svh"
module edge_capture_unit_tb_top;
  logic                ref_clk, reset_n, en, tsel, fclr, run, expFlag;
  ecu_pkg::ecu_mode_t  mode;
  ecu_pkg::ecu_src_t   src;
  logic [3:0]          lvl;
  logic [7:0]          lo, hi;
  logic                flag;
  ecu_pkg::ecu_count_t t1, t2;
  int                  num_errors, n_compared, seed, pre, expHold, k;
  ecu_pkg::ecu_mode_t  modes [6] = '{4'h4, 4'h5, 4'h3, 4'h6, 4'h7, 4'h6};

  ecu_timer_model i_tmr (.ref_clk, .reset_n, .run, .count1(t1), .count2(t2));
  edge_capture_unit i_dut (.ref_clk, .reset_n, .unitEnable(en), .captureMode(mode),
    .captureSourceSel(src), .captureUnitPin(lvl[0]), .internalSources(lvl[3:1]),
    .timerSelect(tsel), .firstOddTimerCount(t1), .secondOddTimerCount(t2),
    .flagClear(fclr), .captureHoldingLow(lo), .captureHoldingHigh(hi),
    .captureEventFlag(flag));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : cyc

  task chk;
    n_compared++;
    if ({hi, lo} !== expHold[15:0] || flag !== expFlag) begin
      num_errors++;
      $display("Error hold/flag expected %h/%b seen %h/%b", expHold[15:0], expFlag, {hi, lo}, flag);
    end
  endtask : chk

  task clr;
    fclr = 1'b1;
    cyc(1);
    fclr = 1'b0;
    expFlag = 1'b0;
    chk();
  endtask : clr

  task cfg(input ecu_pkg::ecu_mode_t m);
    en = 1'b0;
    mode = `ECU_MODE_OFF;
    pre = 0;
    cyc(2);
    k = $random(seed);
    mode = m;
    src = k[1:0];
    tsel = k[2];
    // Source switch may look like an edge, so it settles while off
    cyc(6);
    en = 1'b1;
    cyc(2);
    clr();
  endtask : cfg

  task step;
    logic cap;
    k = $random(seed);
    run = 1'b1;
    cyc(1 + k[2:0]);
    run = 1'b0;
    cyc(1);
    lvl[k[4:3]] = ~lvl[k[4:3]];
    cyc(6);
    cap = 1'b0;
    if (k[4:3] == src) begin
      case (mode)
        `ECU_MODE_ANY:  cap = 1'b1;
        `ECU_MODE_FALL: cap = !lvl[src];
        `ECU_MODE_RISE: cap = lvl[src];
        default: begin
          pre += lvl[src];
          cap = (pre == ((mode == `ECU_MODE_RISE4) ? 4 : 16));
          if (cap) pre = 0;
        end
      endcase
    end
    if (cap) begin
      expHold = tsel ? t2 : t1;
      expFlag = 1'b1;
    end
    chk();
    if (k[5]) clr();
  endtask : step

  task finish_test;
    $display("Compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test

  initial begin
    {en, tsel, fclr, run, expFlag, lvl, mode, src} = '0;
    {num_errors, n_compared, pre, expHold} = '0;
    seed = 32'h38e2;
    reset_n = 1'b0;
    cyc(3);
    reset_n = 1'b1;
    chk();
    foreach (modes[i]) begin
      cfg(modes[i]);
      repeat (40) step();
    end
    finish_test();
  end
endmodule : edge_capture_unit_tb_top
